// File: include/tmr01_consts.svh
`ifndef TMR01_CONSTS_SVH
`define TMR01_CONSTS_SVH
// ==========================================================
// Register indices on APB; the byte address is four times the index
`define IDX_CTL 8'h88
`define IDX_MODE 8'h89
`define IDX_LO0 8'h8a
`define IDX_LO1 8'h8b
`define IDX_HI0 8'h8c
`define IDX_HI1 8'h8d
`define IDX_IRQ_STAT 8'h90
`define IDX_IRQ_MASK 8'h91
`define IDX_ACK 8'h92
// ==========================================================
// Control register fields
`define CTL_OVF1 7
`define CTL_RUN1 6
`define CTL_OVF0 5
`define CTL_RUN0 4
// Mode register nibble fields
`define MODE_GATE 3
`define MODE_SRC 2
`define MODE_HI 1
`define MODE_LO 0
`define MODE_RESET 8'h00
`define CTL_RESET 8'h00
// ==========================================================
// Machine cycle length in system clocks
`define MCYC_CLKS 12
`define PRESC_TOP 5'h1f
`define BYTE_TOP 8'hff
`endif

// File: include/tmr01_pkg.sv
package tmr01_pkg;
  typedef enum logic [1:0] {
    MODE_PRESC13, MODE_CNT16, MODE_RELOAD8, MODE_SPLIT
  } tmode_e;
endpackage : tmr01_pkg

// File: tb/pin_model.sv
`timescale 1ns/1ps
module pin_model #(
  parameter int HOLD = 6
) (
  input wire logic pclk,
  output logic cnt0,
  output logic cnt1
);
  initial begin
    cnt0 = 1'b1;
    cnt1 = 1'b1;
  end
  // Each level is held past a machine cycle, or an edge may be missed
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (HOLD) @(posedge pclk);
      cnt0 <= 1'b0;
      repeat (HOLD) @(posedge pclk);
      cnt0 <= 1'b1;
    end
  endtask : pulse
endmodule : pin_model

// File: tb/tb.sv
`timescale 1ns/1ps
`include "tmr01_consts.svh"
module tb;
  import tmr01_pkg::*;
  localparam int MC = 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cp0, cp1, q0, q1, ack0, ack1, ovf0, ovf1, irq, baud;
  logic [7:0] v, lo;
  logic [1:0] md;
  int n_errors, n_checks, seed, cyc, ticks, n;
  tmr01 #(.MCYC(MC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_pin_unit0(cp0), .count_pin_unit1(cp1),
    .qualify_pin_unit0(q0), .qualify_pin_unit1(q1),
    .vector_ack_unit0(ack0), .vector_ack_unit1(ack1),
    .overflow_irq_unit0(ovf0), .overflow_irq_unit1(ovf1), .irq(irq),
    .baud_tick_unit1(baud));
  pin_model #(.HOLD(3 * MC)) pins (.pclk(pclk), .cnt0(cp0), .cnt1(cp1));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] i, d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  task automatic rdc(input string nm, input logic [7:0] i, e);
    bus(1'b0, i, 8'h00);
    chk(nm, rd, {24'h0, e});
  endtask : rdc
  // Reload mode overflows once per (256 - reload) machine cycles
  function automatic int reload_ticks(input int clks, input int rl);
    return clks / ((256 - rl) * MC);
  endfunction : reload_ticks
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    seed = 39;
    {n_errors, n_checks, cyc} = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {q0, q1, ack0, ack1} = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("mode", `IDX_MODE, `MODE_RESET);
    rdc("ctl", `IDX_CTL, `CTL_RESET);
    bus(1'b0, 8'hff, 8'h00);
    chk("slverr", err, 1'b1);
    for (int m = 0; m < 2; m++) begin
      v = 8'($random(seed));
      md = (m == 0) ? MODE_PRESC13 : MODE_CNT16;
      lo = (m == 0) ? {1'b0, v[6:5], 5'h1f} : 8'hff;
      bus(1'b1, `IDX_CTL, 8'h00);
      bus(1'b1, `IDX_HI0, 8'hff);
      bus(1'b1, `IDX_LO0, lo);
      bus(1'b1, `IDX_MODE, {6'h0, md});
      bus(1'b1, `IDX_CTL, 8'h10);
      repeat (200) if (ovf0 !== 1'b1) @(posedge pclk);
      chk("ovf0", ovf0, 1'b1);
      rdc("hi0", `IDX_HI0, 8'h00);
      rdc("ctl", `IDX_CTL, 8'h30);
      ack0 <= 1'b1;
      @(posedge pclk);
      ack0 <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("ack0", ovf0, 1'b0);
    end
    bus(1'b1, `IDX_CTL, 8'h00);
    v = 8'($random(seed));
    bus(1'b1, `IDX_LO1, v);
    bus(1'b1, `IDX_MODE, {2'b10, MODE_CNT16, 4'h0});
    bus(1'b1, `IDX_CTL, 8'h40);
    repeat (20) @(posedge pclk);
    rdc("gated", `IDX_LO1, v);
    q1 <= 1'b1;
    repeat (20) @(posedge pclk);
    bus(1'b0, `IDX_LO1, 8'h00);
    chk("open", rd[7:0] !== v, 1'b1);
    bus(1'b1, `IDX_CTL, 8'h00);
    bus(1'b1, `IDX_HI1, 8'hfe);
    bus(1'b1, `IDX_LO1, 8'hfe);
    bus(1'b1, `IDX_MODE, {2'b00, MODE_RELOAD8, 4'h0});
    bus(1'b1, `IDX_CTL, 8'h40);
    ticks = 0;
    repeat (40) @(posedge pclk) if (baud === 1'b1) ticks++;
    n = reload_ticks(40, 8'hfe);
    chk("ticks", ticks inside {[n - 1:n + 1]}, 1'b1);
    rdc("reload", `IDX_HI1, 8'hfe);
    chk("ovf1", ovf1, 1'b1);
    bus(1'b1, `IDX_CTL, 8'h00);
    bus(1'b1, `IDX_LO0, 8'h00);
    bus(1'b1, `IDX_MODE, {4'h0, 2'b01, MODE_CNT16});
    bus(1'b1, `IDX_CTL, 8'h10);
    n = 1 + ($random(seed) & 3);
    pins.pulse(n);
    repeat (4 * MC) @(posedge pclk);
    rdc("edges", `IDX_LO0, 8'(n));
    bus(1'b1, `IDX_CTL, 8'h00);
    bus(1'b1, `IDX_HI0, 8'hff);
    bus(1'b1, `IDX_LO1, 8'hfe);
    bus(1'b1, `IDX_MODE, {2'b00, MODE_SPLIT, 2'b00, MODE_SPLIT});
    bus(1'b1, `IDX_CTL, 8'h40);
    repeat (50) if (ovf1 !== 1'b1) @(posedge pclk);
    chk("split", ovf1 & !ovf0, 1'b1);
    rdc("held", `IDX_LO1, 8'hfe);
    // Run bit 1 belongs to unit 0 here; unit 1 must resume without it
    bus(1'b1, `IDX_CTL, 8'h00);
    bus(1'b1, `IDX_MODE, {4'h0, 2'b00, MODE_SPLIT});
    repeat (20) @(posedge pclk);
    bus(1'b0, `IDX_LO1, 8'h00);
    chk("resume", rd[7:0] !== 8'hfe, 1'b1);
    bus(1'b1, `IDX_CTL, 8'h00);
    bus(1'b1, `IDX_IRQ_MASK, 8'h03);
    repeat (2) @(posedge pclk);
    chk("irq on", irq, 1'b1);
    bus(1'b1, `IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge pclk);
    chk("irq mask", irq, 1'b0);
    bus(1'b1, `IDX_IRQ_MASK, 8'h03);
    bus(1'b1, `IDX_IRQ_STAT, 8'h03);
    repeat (2) @(posedge pclk);
    chk("irq clr", irq, 1'b0);
    wrap_up();
  end
endmodule : tb

// File: tb/tmr01_assertions.sv
`timescale 1ns/1ps
module tmr01_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic vector_ack_unit0,
  input wire logic vector_ack_unit1,
  input wire logic overflow_irq_unit0,
  input wire logic overflow_irq_unit1,
  input wire logic irq,
  input wire logic baud_tick_unit1
);
  logic [2:0] since_r;
  // Flags and irq may only fall shortly after a write or an ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_r <= 3'h0;
    else if (vector_ack_unit0 || vector_ack_unit1 || (psel && pwrite))
      since_r <= 3'h0;
    else if (since_r != 3'h7)
      since_r <= since_r + 3'h1;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_baud_single: assert property (
    baud_tick_unit1 |=> !baud_tick_unit1)
    else $error("baud tick too long");
  chk_ovf0_fall: assert property (
    $fell(overflow_irq_unit0) |-> since_r < 3'h3)
    else $error("flag 0 fell without cause");
  chk_ovf1_fall: assert property (
    $fell(overflow_irq_unit1) |-> since_r < 3'h3)
    else $error("flag 1 fell without cause");
  chk_irq_fall: assert property ($fell(irq) |-> since_r < 3'h3)
    else $error("irq fell without cause");
endmodule : tmr01_assertions
bind tmr01 tmr01_assertions chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .vector_ack_unit0(vector_ack_unit0),
  .vector_ack_unit1(vector_ack_unit1),
  .overflow_irq_unit0(overflow_irq_unit0),
  .overflow_irq_unit1(overflow_irq_unit1), .irq(irq),
  .baud_tick_unit1(baud_tick_unit1));

// File: verilog/tmr01.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "tmr01_consts.svh"
// Contract
// - Gate bit set: count only while run bit set and qualify pin high.
// - Source bit set counts external pin edges, else internal cycles.
// - Mode bits: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split.
// - Mode 0 counts in 13 bits; rollover to zero sets overflow flag.
// - Mode 0 uses high byte plus low five bits; top three undefined.
// - Setting the run bit does not clear the count registers.
// - Gate bit of unit 1 at mode bit 7, unit 0 at bit 3.
// - Mode 1 is a full 16-bit counter setting overflow on rollover.
// - Mode 2: low byte overflow sets flag, reloads from high byte.
// - Unit 1 in mode 3 holds its count as if run bit cleared.
// - Split mode: unit 0 low byte uses unit 0 controls and flag.
// - Split: unit 0 high byte counts cycles, uses unit 1 run/flag.
// - Unit 1 runs outside mode 3, halts in it; rollover still seen.
// - Overflow flag is an interrupt request source for its unit.
// - Timer function advances once per machine cycle of 12 clocks.
// - Count pin sampled per machine cycle; high then low counts.
// - Overflow flag cleared by hardware on interrupt vectoring.
// - Control reg: bit7 ovf1, bit6 run1, bit5 ovf0, bit4 run0.
module tmr01 #(
  parameter int MCYC = `MCYC_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_pin_unit0,
  input wire logic count_pin_unit1,
  input wire logic qualify_pin_unit0,
  input wire logic qualify_pin_unit1,
  input wire logic vector_ack_unit0,
  input wire logic vector_ack_unit1,
  output logic overflow_irq_unit0,
  output logic overflow_irq_unit1,
  output logic irq,
  output logic baud_tick_unit1
);
  import tmr01_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {qualify_pin_unit1, qualify_pin_unit0,
                   count_pin_unit1, count_pin_unit0};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ==========================================================
  // Machine cycle timing
  logic [7:0] mcyc_r;
  logic mtick;
  assign mtick = (mcyc_r == 8'(MCYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcyc_r <= 8'h00;
    end else if (mtick) begin
      mcyc_r <= 8'h00;
    end else begin
      mcyc_r <= mcyc_r + 8'h01;
    end
  end

  // Samples of the count pins once per machine cycle
  logic [1:0] samp_r;
  logic [1:0] samp_prev_r;
  logic [1:0] fall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_r <= 2'h0;
      samp_prev_r <= 2'h0;
    end else if (mtick) begin
      samp_r <= pin_s2_r[1:0];
      samp_prev_r <= samp_r;
    end
  end
  assign fall = samp_prev_r & ~samp_r;

  // ==========================================================
  // Registers
  logic [7:0] mode_r;
  logic [7:0] ctl_r;
  logic [7:0] lo_r [2];
  logic [7:0] hi_r [2];
  logic [1:0] stat_r;
  logic [1:0] mask_r;

  logic wr_en;
  logic [7:0] idx;
  logic mapped;
  assign idx = paddr[9:2];
  assign wr_en = psel && penable && pwrite;
  always_comb begin
    unique case (idx)
      `IDX_CTL, `IDX_MODE, `IDX_LO0, `IDX_LO1, `IDX_HI0, `IDX_HI1,
      `IDX_IRQ_STAT, `IDX_IRQ_MASK, `IDX_ACK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // Count enables and next values per unit
  logic [1:0] run;
  logic [1:0] inc;
  logic hi0_inc;
  logic [7:0] lo_nxt [2];
  logic [7:0] hi_nxt [2];
  logic [1:0] ovf;
  logic ovf_hi0;
  tmode_e m0;
  tmode_e m1;
  assign m0 = tmode_e'(mode_r[1:0]);
  assign m1 = tmode_e'(mode_r[5:4]);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_unit
      logic gate;
      logic src;
      logic qual;
      logic runb;
      tmode_e md;
      assign gate = mode_r[4*g + `MODE_GATE];
      assign src = mode_r[4*g + `MODE_SRC];
      assign md = tmode_e'(mode_r[4*g+1 -: 2]);
      assign qual = pin_s2_r[2+g];
      // Split unit 0 takes run bit 1; unit 1 then runs on its mode alone
      assign runb = (g == 1 && m0 == MODE_SPLIT)
                    || ctl_r[g ? `CTL_RUN1 : `CTL_RUN0];
      // Unit 1 in split mode holds count
      assign run[g] = runb && (!gate || qual)
                      && !(g == 1 && md == MODE_SPLIT);
      // The sample pair stands a whole machine cycle, so count it once
      assign inc[g] = run[g] && mtick && (!src || fall[g]);
      always_comb begin
        lo_nxt[g] = lo_r[g];
        hi_nxt[g] = hi_r[g];
        ovf[g] = 1'b0;
        if (inc[g]) begin
          unique case (md)
            MODE_PRESC13: begin
              lo_nxt[g] = {lo_r[g][7:5], lo_r[g][4:0] + 5'h01};
              if (lo_r[g][4:0] == `PRESC_TOP) begin
                hi_nxt[g] = hi_r[g] + 8'h01;
                ovf[g] = (hi_r[g] == `BYTE_TOP);
              end
            end
            MODE_CNT16: begin
              lo_nxt[g] = lo_r[g] + 8'h01;
              if (lo_r[g] == `BYTE_TOP) begin
                hi_nxt[g] = hi_r[g] + 8'h01;
                ovf[g] = (hi_r[g] == `BYTE_TOP);
              end
            end
            MODE_RELOAD8: begin
              if (lo_r[g] == `BYTE_TOP) begin
                lo_nxt[g] = hi_r[g];
                ovf[g] = 1'b1;
              end else begin
                lo_nxt[g] = lo_r[g] + 8'h01;
              end
            end
            MODE_SPLIT: begin
              lo_nxt[g] = lo_r[g] + 8'h01;
              ovf[g] = (lo_r[g] == `BYTE_TOP);
            end
          endcase
        end
      end
    end
  endgenerate

  // Split mode: unit 0 high byte is a cycle timer on unit 1 run bit
  assign hi0_inc = (m0 == MODE_SPLIT) && ctl_r[`CTL_RUN1] && mtick;
  assign ovf_hi0 = hi0_inc && (hi_r[0] == `BYTE_TOP);

  // Overflow events routed to flags
  logic ev0;
  logic ev1;
  logic unit1_roll;
  assign ev0 = ovf[0];
  assign unit1_roll = ovf[1];
  assign ev1 = (m0 == MODE_SPLIT) ? ovf_hi0 : unit1_roll;

  // ==========================================================
  // Count registers; software write loses to nothing, count resumes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_r[0] <= 8'h00;
      lo_r[1] <= 8'h00;
      hi_r[0] <= 8'h00;
      hi_r[1] <= 8'h00;
    end else begin
      lo_r[1] <= (wr_en && idx == `IDX_LO1) ? pwdata[7:0] : lo_nxt[1];
      hi_r[1] <= (wr_en && idx == `IDX_HI1) ? pwdata[7:0] : hi_nxt[1];
      lo_r[0] <= (wr_en && idx == `IDX_LO0) ? pwdata[7:0] : lo_nxt[0];
      if (wr_en && idx == `IDX_HI0) begin
        hi_r[0] <= pwdata[7:0];
      end else if (hi0_inc) begin
        hi_r[0] <= hi_r[0] + 8'h01;
      end else begin
        hi_r[0] <= hi_nxt[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `MODE_RESET;
    end else if (wr_en && idx == `IDX_MODE) begin
      mode_r <= pwdata[7:0];
    end
  end

  // Run bits written directly; counts untouched by them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= `CTL_RESET;
    end else begin
      if (wr_en && idx == `IDX_CTL) begin
        ctl_r <= pwdata[7:0];
      end
      if (vector_ack_unit0) begin
        ctl_r[`CTL_OVF0] <= 1'b0;
      end
      if (vector_ack_unit1) begin
        ctl_r[`CTL_OVF1] <= 1'b0;
      end
      // Set wins over any clear in the same cycle
      if (ev0) begin
        ctl_r[`CTL_OVF0] <= 1'b1;
      end
      if (ev1) begin
        ctl_r[`CTL_OVF1] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Sticky interrupt status, write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 2'h0;
      mask_r <= 2'h0;
    end else begin
      if (wr_en && idx == `IDX_IRQ_MASK) begin
        mask_r <= pwdata[1:0];
      end
      stat_r <= (stat_r & ~((wr_en && idx == `IDX_IRQ_STAT) ?
                 pwdata[1:0] : 2'h0)) | {ev1, ev0};
    end
  end

  // ==========================================================
  // Outputs and APB read path; zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_unit0 <= 1'b0;
      overflow_irq_unit1 <= 1'b0;
      irq <= 1'b0;
      baud_tick_unit1 <= 1'b0;
    end else begin
      overflow_irq_unit0 <= ctl_r[`CTL_OVF0];
      overflow_irq_unit1 <= ctl_r[`CTL_OVF1];
      irq <= |(stat_r & mask_r);
      // Baud source stays usable in split mode, no flag needed
      baud_tick_unit1 <= unit1_roll;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (idx)
          `IDX_CTL: prdata <= {24'h0, ctl_r};
          `IDX_MODE: prdata <= {24'h0, mode_r};
          `IDX_LO0: prdata <= {24'h0, lo_r[0]};
          `IDX_LO1: prdata <= {24'h0, lo_r[1]};
          `IDX_HI0: prdata <= {24'h0, hi_r[0]};
          `IDX_HI1: prdata <= {24'h0, hi_r[1]};
          `IDX_IRQ_STAT: prdata <= {30'h0, stat_r};
          `IDX_IRQ_MASK: prdata <= {30'h0, mask_r};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule : tmr01
